// ===== sim/cbl_exec_bench.sv
`timescale 1ns/1ps
module cbl_exec_bench
    import cbl_pkg::*;
;
    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic instr_valid_i = 1'b0;
    cbl_instr_s instr_i = '0;
    logic [7:0] flags_i = 8'h00;
    logic [7:0] mem_rdata_i = 8'h00;
    logic ready_o;
    logic done_o;
    logic [PC_W-1:0] pc_o;
    logic mem_rd_o;
    logic [ADDR_W-1:0] mem_addr_o;
    logic [7:0] flags_o;
    logic [NUM_REGS*8-1:0] regs_o;
    int fail_count = 0;
    int cmp_count = 0;
    int cycles = 0;
    logic [15:0] exp_pc = 16'h0000;
    logic [7:0] fpat [4] = '{8'h00, 8'hff, 8'h04, 8'h08};

    always #2 clk_i = ~clk_i;

    cbl_exec cbl_exec_i (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .instr_valid_i(instr_valid_i),
        .instr_i(instr_i),
        .flags_i(flags_i),
        .mem_rdata_i(mem_rdata_i),
        .ready_o(ready_o),
        .done_o(done_o),
        .pc_o(pc_o),
        .mem_rd_o(mem_rd_o),
        .mem_addr_o(mem_addr_o),
        .flags_o(flags_o),
        .regs_o(regs_o)
    );

    // ------------------------------------------------------------
    // reporting
    // ------------------------------------------------------------
    task automatic end_sim();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // whole run is about 130 cycles; ceiling leaves wide margin
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            end_sim();
        end
    end

    task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_cyc(input int got, input int exp);
        cmp_count++;
        if (got != exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic [7:0] rg(input int n);
        return regs_o[8*n +: 8];
    endfunction

    function automatic cbl_instr_s mk(input cbl_op_e op, input logic [4:0] rd, input logic [4:0] rr,
                                      input cbl_ptr_e p, input logic [6:0] off, input logic [5:0] d,
                                      input logic [7:0] imm, input logic [15:0] a);
        cbl_instr_s s;
        s.op = op;
        s.rd = rd;
        s.rr = rr;
        s.ptr = p;
        s.offset = off;
        s.disp = d;
        s.imm = imm;
        s.abs_addr = a;
        return s;
    endfunction

    function automatic logic taken(input cbl_op_e op, input logic [7:0] f);
        case (op)
            CBL_BRANCH_IF_NONNEGATIVE: return !f[FLG_N];
            CBL_BRANCH_SIGNED_GE: return !(f[FLG_N] ^ f[FLG_V]);
            CBL_BRANCH_SIGNED_LESS: return f[FLG_N] ^ f[FLG_V];
            CBL_BRANCH_HALF_CARRY_SET: return f[FLG_H];
            CBL_BRANCH_HALF_CARRY_CLEAR: return !f[FLG_H];
            CBL_BRANCH_TRANSFER_BIT_SET: return f[FLG_T];
            CBL_BRANCH_IRQ_ENABLED: return f[FLG_I];
            default: return !f[FLG_I];
        endcase
    endfunction

    // ------------------------------------------------------------
    // access protocol: offer one instruction, count edges to done
    // ------------------------------------------------------------
    task automatic run(input cbl_instr_s ins, input logic [7:0] fl, input logic [7:0] rd_data,
                       output int cyc, output int rds, output logic [15:0] addr);
        int n;
        n = 0;
        while (ready_o !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        @(posedge clk_i);
        instr_valid_i <= 1'b1;
        instr_i <= ins;
        flags_i <= fl;
        mem_rdata_i <= ~rd_data;
        @(posedge clk_i);
        instr_valid_i <= 1'b0;
        mem_rdata_i <= rd_data;
        cyc = 1;
        rds = 0;
        addr = 16'h0000;
        #1;
        while (done_o !== 1'b1 && cyc < 8) begin
            cmp_val(ready_o, 16'h0000);
            if (mem_rd_o === 1'b1) begin
                rds++;
                addr = mem_addr_o;
            end
            @(posedge clk_i);
            #1;
            cyc++;
        end
    endtask

    task automatic lc(input int n, input logic [7:0] v);
        int cyc;
        int rds;
        logic [15:0] a;
        run(mk(CBL_LOAD_CONSTANT, n[4:0], 5'h00, CBL_PTR_X, 7'h00, 6'h00, v, 16'h0000), 8'h3c, 8'h00, cyc, rds, a);
        exp_pc = exp_pc + 16'h0001;
        cmp_val(rg(n), v);
        cmp_cyc(cyc, 1);
        cmp_val(flags_o, 8'h3c);
        cmp_val(pc_o, exp_pc);
    endtask

    // loads: ea is the expected read address, ep the pointer afterwards
    task automatic ld(input cbl_op_e op, input cbl_ptr_e p, input logic [5:0] d, input logic [15:0] ab,
                      input int rd, input logic [7:0] v, input logic [15:0] ea, input int lo,
                      input logic [15:0] ep);
        int cyc;
        int rds;
        logic [15:0] a;
        run(mk(op, rd[4:0], 5'h00, p, 7'h00, d, 8'h00, ab), 8'hc3, v, cyc, rds, a);
        exp_pc = exp_pc + 16'h0001;
        cmp_val(a, ea);
        cmp_cyc(rds, 1);
        cmp_cyc(cyc, 2);
        cmp_val(rg(rd), v);
        cmp_val({rg(lo + 1), rg(lo)}, ep);
        cmp_val(flags_o, 8'hc3);
        cmp_val(pc_o, exp_pc);
    endtask

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        int cyc;
        int rds;
        logic [15:0] a;
        logic [6:0] off;
        logic tk;
        cbl_op_e op;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        #1;
        cmp_val(pc_o, PC_RST);
        cmp_cyc(int'(regs_o === '0), 1);
        cmp_val(done_o, 16'h0000);
        cmp_val(ready_o, 16'h0001);
        // every branch kind, both outcomes, both ends of the offset range
        for (int i = 1; i <= 8; i++) begin
            for (int j = 0; j < 4; j++) begin
                op = cbl_op_e'(i);
                off = j[0] ? 7'h40 : 7'h3f;
                tk = taken(op, fpat[j]);
                run(mk(op, 5'h00, 5'h00, CBL_PTR_X, off, 6'h00, 8'h00, 16'h0000), fpat[j], 8'h00, cyc, rds, a);
                exp_pc = tk ? exp_pc + {{9{off[6]}}, off} + 16'h0001 : exp_pc + 16'h0001;
                cmp_val(pc_o, exp_pc);
                cmp_cyc(cyc, tk ? 2 : 1);
                cmp_val(flags_o, fpat[j]);
            end
        end
        // pointers: x = 01fe, y = 0100, z = 10c1
        lc(26, 8'hfe);
        lc(27, 8'h01);
        lc(28, 8'h00);
        lc(29, 8'h01);
        lc(30, 8'hc1);
        lc(31, 8'h10);
        ld(CBL_LOAD_POINTER_INDIRECT, CBL_PTR_X, 6'h00, 16'h0000, 5, 8'ha5, 16'h01fe, 26, 16'h01fe);
        ld(CBL_LOAD_POST_INC, CBL_PTR_X, 6'h00, 16'h0000, 6, 8'h5a, 16'h01fe, 26, 16'h01ff);
        ld(CBL_LOAD_PRE_DEC, CBL_PTR_Y, 6'h00, 16'h0000, 7, 8'h3c, 16'h00ff, 28, 16'h00ff);
        ld(CBL_LOAD_WITH_OFFSET, CBL_PTR_Z, 6'h3f, 16'h0000, 8, 8'hc3, 16'h1100, 30, 16'h10c1);
        ld(CBL_LOAD_WITH_OFFSET, CBL_PTR_Y, 6'h02, 16'h0000, 9, 8'h81, 16'h0101, 28, 16'h00ff);
        ld(CBL_LOAD_ABSOLUTE_ADDRESS, CBL_PTR_X, 6'h00, 16'hffff, 10, 8'h99, 16'hffff, 26, 16'h01ff);
        // register copy, then pair copy with odd indices: low bit of both is ignored
        run(mk(CBL_COPY_REGISTER, 5'h00, 5'h1a, CBL_PTR_X, 7'h00, 6'h00, 8'h00, 16'h0000), 8'h5a, 8'h00, cyc, rds, a);
        cmp_val(rg(0), 8'hff);
        cmp_cyc(cyc + rds, 1);
        run(mk(CBL_COPY_REGISTER_PAIR, 5'h03, 5'h1f, CBL_PTR_X, 7'h00, 6'h00, 8'h00, 16'h0000),
            8'h5a, 8'h00, cyc, rds, a);
        exp_pc = exp_pc + 16'h0002;
        cmp_val({rg(3), rg(2)}, 16'h10c1);
        cmp_cyc(cyc, 1);
        cmp_val(flags_o, 8'h5a);
        cmp_val(pc_o, exp_pc);
        // reset again mid-run: everything must go back to its reset values
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        #1;
        cmp_val(pc_o, PC_RST);
        cmp_cyc(int'(regs_o === '0), 1);
        cmp_val(ready_o, 16'h0001);
        // CBL_NOP, decoded by the default arm, runs as a one-cycle no-op
        exp_pc = PC_RST + 16'h0001;
        run(mk(CBL_NOP, 5'h00, 5'h00, CBL_PTR_X, 7'h00, 6'h00, 8'h00, 16'h0000), 8'h00, 8'h00, cyc, rds, a);
        cmp_val(pc_o, exp_pc);
        cmp_cyc(cyc + rds, 1);
        end_sim();
    end
endmodule

// ===== verilog/cbl_exec.sv
`timescale 1ns/1ps
// Functional notes
// RULE_01 - branch_if_nonnegative: pc gets pc+k+1 when N is zero; 1 or 2 cycles
// RULE_02 - branch_signed_ge: jump when N xor V is zero; flags kept; 1 or 2 cycles
// RULE_03 - branch_signed_less: jump when N xor V is one; flags kept; 1 or 2 cycles
// RULE_04 - branch_half_carry_set: jump when H is one; flags kept; 1 or 2 cycles
// RULE_05 - branch_half_carry_clear: jump when H is zero; flags kept; 1 or 2 cycles
// RULE_06 - branch_transfer_bit_set: jump when T is one; flags kept; 1 or 2 cycles
// RULE_07 - branch_irq_enabled: jump when I is one; flags kept; 1 or 2 cycles
// RULE_08 - branch_irq_disabled: jump when I is zero; flags kept; 1 or 2 cycles
// RULE_09 - pointer load in two cycles; plain keeps pointer, post-inc adds one after
// RULE_10 - pre-decrement load: pointer minus one first, read at new value, two cycles
// RULE_11 - offset load reads Y or Z plus unsigned displacement, pointer unchanged
// RULE_12 - absolute load reads the addressed data location in two cycles
// RULE_13 - register copy, pair copy, constant load: one cycle, flags kept
// RULE_14 - branch offset is two's complement, reaching backward and forward
module cbl_exec
    import cbl_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic instr_valid_i,
    input wire cbl_instr_s instr_i,
    input wire logic [7:0] flags_i,
    input wire logic [7:0] mem_rdata_i,
    output logic ready_o,
    output logic done_o,
    output logic [PC_W-1:0] pc_o,
    output logic mem_rd_o,
    output logic [ADDR_W-1:0] mem_addr_o,
    output logic [7:0] flags_o,
    output logic [NUM_REGS*8-1:0] regs_o
);

    typedef enum logic [1:0] {
        CBL_ST_IDLE,
        CBL_ST_BR2,
        CBL_ST_LD2
    } cbl_state_e;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [ADDR_W-1:0] ptr_val(input logic [7:0] rf [NUM_REGS], input cbl_ptr_e p);
        logic [4:0] lo;
        lo = (p == CBL_PTR_X) ? PTR_X_LO : (p == CBL_PTR_Y) ? PTR_Y_LO : PTR_Z_LO;
        return {rf[lo + 5'h01], rf[lo]};
    endfunction

    function automatic logic [4:0] ptr_lo(input cbl_ptr_e p);
        return (p == CBL_PTR_X) ? PTR_X_LO : (p == CBL_PTR_Y) ? PTR_Y_LO : PTR_Z_LO;
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    cbl_state_e state_ff, nxt_state;
    logic [PC_W-1:0] pc_ff, nxt_pc;
    logic [PC_W-1:0] target_ff, nxt_target;
    logic [REG_IDX_W-1:0] ld_rd_ff, nxt_ld_rd;
    logic [7:0] rf_ff [NUM_REGS];
    logic [7:0] nxt_rf [NUM_REGS];
    logic done_ff, nxt_done;
    logic mem_rd_ff, nxt_mem_rd;
    logic [ADDR_W-1:0] mem_addr_ff, nxt_mem_addr;
    logic take;
    logic [ADDR_W-1:0] ptr_cur;
    logic [PC_W-1:0] off_ext;
    logic [4:0] plo;

    always_comb begin
        case (instr_i.op)
            CBL_BRANCH_IF_NONNEGATIVE: take = !flags_i[FLG_N]; // RULE_01
            CBL_BRANCH_SIGNED_GE: take = !(flags_i[FLG_N] ^ flags_i[FLG_V]); // RULE_02
            CBL_BRANCH_SIGNED_LESS: take = flags_i[FLG_N] ^ flags_i[FLG_V]; // RULE_03
            CBL_BRANCH_HALF_CARRY_SET: take = flags_i[FLG_H]; // RULE_04
            CBL_BRANCH_HALF_CARRY_CLEAR: take = !flags_i[FLG_H]; // RULE_05
            CBL_BRANCH_TRANSFER_BIT_SET: take = flags_i[FLG_T]; // RULE_06
            CBL_BRANCH_IRQ_ENABLED: take = flags_i[FLG_I]; // RULE_07
            CBL_BRANCH_IRQ_DISABLED: take = !flags_i[FLG_I]; // RULE_08
            default: take = 1'b0;
        endcase
    end

    // sign extension lets the jump reach backward
    assign off_ext = {{(PC_W-OFF_W){instr_i.offset[OFF_W-1]}}, instr_i.offset}; // RULE_14
    assign plo = ptr_lo(instr_i.ptr);
    assign ptr_cur = ptr_val(rf_ff, instr_i.ptr);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_pc = pc_ff;
        nxt_target = target_ff;
        nxt_ld_rd = ld_rd_ff;
        nxt_rf = rf_ff;
        nxt_done = 1'b0;
        nxt_mem_rd = 1'b0;
        nxt_mem_addr = mem_addr_ff;
        case (state_ff)
            CBL_ST_IDLE: begin
                if (instr_valid_i) begin
                    case (instr_i.op)
                        CBL_BRANCH_IF_NONNEGATIVE, CBL_BRANCH_SIGNED_GE, CBL_BRANCH_SIGNED_LESS,
                        CBL_BRANCH_HALF_CARRY_SET, CBL_BRANCH_HALF_CARRY_CLEAR,
                        CBL_BRANCH_TRANSFER_BIT_SET, CBL_BRANCH_IRQ_ENABLED,
                        CBL_BRANCH_IRQ_DISABLED: begin
                            if (take) begin
                                // taken branch spends a second cycle
                                nxt_target = pc_ff + off_ext + PC_STEP; // RULE_01
                                nxt_state = CBL_ST_BR2;
                            end else begin
                                nxt_pc = pc_ff + PC_STEP;
                                nxt_done = 1'b1;
                            end
                        end
                        CBL_COPY_REGISTER: begin
                            nxt_rf[instr_i.rd] = rf_ff[instr_i.rr]; // RULE_13
                            nxt_pc = pc_ff + PC_STEP;
                            nxt_done = 1'b1;
                        end
                        CBL_COPY_REGISTER_PAIR: begin
                            nxt_rf[{instr_i.rd[4:1], 1'b0}] = rf_ff[{instr_i.rr[4:1], 1'b0}]; // RULE_13
                            nxt_rf[{instr_i.rd[4:1], 1'b1}] = rf_ff[{instr_i.rr[4:1], 1'b1}];
                            nxt_pc = pc_ff + PC_STEP;
                            nxt_done = 1'b1;
                        end
                        CBL_LOAD_CONSTANT: begin
                            nxt_rf[instr_i.rd] = instr_i.imm; // RULE_13
                            nxt_pc = pc_ff + PC_STEP;
                            nxt_done = 1'b1;
                        end
                        CBL_LOAD_POINTER_INDIRECT, CBL_LOAD_POST_INC: begin
                            nxt_mem_addr = ptr_cur; // RULE_09
                            nxt_mem_rd = 1'b1;
                            nxt_ld_rd = instr_i.rd;
                            nxt_state = CBL_ST_LD2;
                            if (instr_i.op == CBL_LOAD_POST_INC) begin
                                {nxt_rf[plo + 5'h01], nxt_rf[plo]} = ptr_cur + PTR_STEP; // RULE_09
                            end
                        end
                        CBL_LOAD_PRE_DEC: begin
                            nxt_mem_addr = ptr_cur - PTR_STEP; // RULE_10
                            {nxt_rf[plo + 5'h01], nxt_rf[plo]} = ptr_cur - PTR_STEP;
                            nxt_mem_rd = 1'b1;
                            nxt_ld_rd = instr_i.rd;
                            nxt_state = CBL_ST_LD2;
                        end
                        CBL_LOAD_WITH_OFFSET: begin
                            // x has no displacement form; it is read as z
                            nxt_mem_addr = ptr_val(rf_ff, (instr_i.ptr == CBL_PTR_Y) ? CBL_PTR_Y : CBL_PTR_Z)
                                + {{(ADDR_W-DISP_W){1'b0}}, instr_i.disp}; // RULE_11
                            nxt_mem_rd = 1'b1;
                            nxt_ld_rd = instr_i.rd;
                            nxt_state = CBL_ST_LD2;
                        end
                        CBL_LOAD_ABSOLUTE_ADDRESS: begin
                            nxt_mem_addr = instr_i.abs_addr; // RULE_12
                            nxt_mem_rd = 1'b1;
                            nxt_ld_rd = instr_i.rd;
                            nxt_state = CBL_ST_LD2;
                        end
                        default: begin
                            nxt_pc = pc_ff + PC_STEP;
                            nxt_done = 1'b1;
                        end
                    endcase
                end
            end
            CBL_ST_BR2: begin
                nxt_pc = target_ff; // RULE_01
                nxt_done = 1'b1;
                nxt_state = CBL_ST_IDLE;
            end
            CBL_ST_LD2: begin
                // data answers in the same cycle as the strobe
                nxt_rf[ld_rd_ff] = mem_rdata_i; // RULE_09
                nxt_pc = pc_ff + PC_STEP;
                nxt_done = 1'b1;
                nxt_state = CBL_ST_IDLE;
            end
            default: nxt_state = CBL_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= CBL_ST_IDLE;
            pc_ff <= PC_RST;
            target_ff <= PC_RST;
            ld_rd_ff <= '0;
            done_ff <= 1'b0;
            mem_rd_ff <= 1'b0;
            mem_addr_ff <= '0;
            for (int i = 0; i < NUM_REGS; i++) begin
                rf_ff[i] <= REG_RST;
            end
        end else begin
            state_ff <= nxt_state;
            pc_ff <= nxt_pc;
            target_ff <= nxt_target;
            ld_rd_ff <= nxt_ld_rd;
            done_ff <= nxt_done;
            mem_rd_ff <= nxt_mem_rd;
            mem_addr_ff <= nxt_mem_addr;
            rf_ff <= nxt_rf;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    logic ready_ff, nxt_ready;
    logic [7:0] flags_ff, nxt_flags;

    always_comb begin
        // ready looks one step ahead so it stays a flop and is still current
        nxt_ready = (nxt_state == CBL_ST_IDLE);
        // none of these operations alter flags
        nxt_flags = flags_i; // RULE_02
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ready_ff <= 1'b0;
            flags_ff <= '0;
        end else begin
            ready_ff <= nxt_ready;
            flags_ff <= nxt_flags;
        end
    end

    assign ready_o = ready_ff;
    assign flags_o = flags_ff;
    assign done_o = done_ff;
    assign pc_o = pc_ff;
    assign mem_rd_o = mem_rd_ff;
    assign mem_addr_o = mem_addr_ff;

    genvar g;
    generate
        for (g = 0; g < NUM_REGS; g++) begin : g_regs
            assign regs_o[g*8 +: 8] = rf_ff[g];
        end
    endgenerate

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic accept;
    assign accept = instr_valid_i && state_ff == CBL_ST_IDLE;

    branch_taken_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_01
        accept && take |=> state_ff == CBL_ST_BR2
        ##1 done_ff && pc_ff == $past(pc_ff, 2) + $past(off_ext, 2) + PC_STEP)
        else $error("taken branch target wrong");
    branch_nontaken_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_02
        accept && instr_i.op == CBL_BRANCH_SIGNED_GE && (flags_i[FLG_N] ^ flags_i[FLG_V]) |=>
        done_ff && pc_ff == $past(pc_ff) + PC_STEP)
        else $error("signed ge branch taken wrongly");
    less_taken_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_03
        accept && instr_i.op == CBL_BRANCH_SIGNED_LESS && (flags_i[FLG_N] ^ flags_i[FLG_V]) |=>
        state_ff == CBL_ST_BR2)
        else $error("signed less branch not taken");
    half_set_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_04
        accept && instr_i.op == CBL_BRANCH_HALF_CARRY_SET && !flags_i[FLG_H] |=> done_ff)
        else $error("half carry branch taken wrongly");
    irq_dis_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_08
        accept && instr_i.op == CBL_BRANCH_IRQ_DISABLED && !flags_i[FLG_I] |=> !done_ff ##1 done_ff)
        else $error("irq disabled branch timing wrong");
    load_two_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_09
        mem_rd_o |=> done_ff && rf_ff[$past(ld_rd_ff)] == $past(mem_rdata_i))
        else $error("load did not finish in two cycles");
    pre_dec_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_10
        accept && instr_i.op == CBL_LOAD_PRE_DEC |=> mem_addr_o == $past(ptr_cur) - PTR_STEP)
        else $error("pre decrement address wrong");
    abs_load_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_12
        accept && instr_i.op == CBL_LOAD_ABSOLUTE_ADDRESS |=> mem_rd_o && mem_addr_o == $past(instr_i.abs_addr))
        else $error("absolute load address wrong");
    const_load_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_13
        accept && instr_i.op == CBL_LOAD_CONSTANT |=> done_ff && rf_ff[$past(instr_i.rd)] == $past(instr_i.imm))
        else $error("constant load wrong");
    half_clear_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_05
        accept && instr_i.op == CBL_BRANCH_HALF_CARRY_CLEAR && !flags_i[FLG_H] |=> state_ff == CBL_ST_BR2)
        else $error("half carry clear branch not taken");
    t_bit_set_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_06
        accept && instr_i.op == CBL_BRANCH_TRANSFER_BIT_SET && flags_i[FLG_T] |=> state_ff == CBL_ST_BR2)
        else $error("transfer bit branch not taken");
    irq_en_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_07
        accept && instr_i.op == CBL_BRANCH_IRQ_ENABLED && !flags_i[FLG_I] |=>
        done_ff && pc_ff == $past(pc_ff) + PC_STEP)
        else $error("irq enabled branch taken wrongly");
    post_inc_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_09
        accept && instr_i.op == CBL_LOAD_POST_INC && instr_i.ptr == CBL_PTR_X |=>
        mem_addr_o == {$past(rf_ff[PTR_X_LO + 5'h01]), $past(rf_ff[PTR_X_LO])}
        && {rf_ff[PTR_X_LO + 5'h01], rf_ff[PTR_X_LO]} == mem_addr_o + PTR_STEP)
        else $error("post increment load wrong");
    offset_load_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_11
        accept && instr_i.op == CBL_LOAD_WITH_OFFSET && instr_i.ptr == CBL_PTR_Y |=>
        mem_addr_o == {$past(rf_ff[PTR_Y_LO + 5'h01]), $past(rf_ff[PTR_Y_LO])} + $past(instr_i.disp)
        && rf_ff[PTR_Y_LO] == $past(rf_ff[PTR_Y_LO])
        && rf_ff[PTR_Y_LO + 5'h01] == $past(rf_ff[PTR_Y_LO + 5'h01]))
        else $error("displacement load wrong");
    pair_copy_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_13
        accept && instr_i.op == CBL_COPY_REGISTER_PAIR |=> done_ff
        && rf_ff[{$past(instr_i.rd[4:1]), 1'b0}] == $past(rf_ff[{instr_i.rr[4:1], 1'b0}])
        && rf_ff[{$past(instr_i.rd[4:1]), 1'b1}] == $past(rf_ff[{instr_i.rr[4:1], 1'b1}]))
        else $error("register pair copy wrong");

    taken_branch_c: cover property (@(posedge clk_i) accept && take);
    backward_branch_c: cover property (@(posedge clk_i) accept && take && instr_i.offset[OFF_W-1]);
    post_inc_c: cover property (@(posedge clk_i) accept && instr_i.op == CBL_LOAD_POST_INC);
    offset_load_c: cover property (@(posedge clk_i) accept && instr_i.op == CBL_LOAD_WITH_OFFSET);
    load_done_c: cover property (@(posedge clk_i) mem_rd_o ##1 done_o);

endmodule

// ===== verilog/cbl_pkg.sv
package cbl_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int PC_W = 16;
    localparam int ADDR_W = 16;
    localparam int OFF_W = 7;
    localparam int DISP_W = 6;
    localparam int REG_IDX_W = 5;
    localparam int NUM_REGS = 32;

    // ------------------------------------------------------------
    // register file positions
    // ------------------------------------------------------------
    localparam logic [4:0] PTR_X_LO = 5'h1a;
    localparam logic [4:0] PTR_Y_LO = 5'h1c;
    localparam logic [4:0] PTR_Z_LO = 5'h1e;

    // ------------------------------------------------------------
    // status flag bit positions
    // ------------------------------------------------------------
    localparam int FLG_C = 0;
    localparam int FLG_Z = 1;
    localparam int FLG_N = 2;
    localparam int FLG_V = 3;
    localparam int FLG_S = 4;
    localparam int FLG_H = 5;
    localparam int FLG_T = 6;
    localparam int FLG_I = 7;

    localparam logic [PC_W-1:0] PC_RST = 16'h0000;
    localparam logic [PC_W-1:0] PC_STEP = 16'h0001;
    localparam logic [ADDR_W-1:0] PTR_STEP = 16'h0001;
    localparam logic [7:0] REG_RST = 8'h00;

    // ------------------------------------------------------------
    // operations
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        CBL_NOP,
        CBL_BRANCH_IF_NONNEGATIVE,
        CBL_BRANCH_SIGNED_GE,
        CBL_BRANCH_SIGNED_LESS,
        CBL_BRANCH_HALF_CARRY_SET,
        CBL_BRANCH_HALF_CARRY_CLEAR,
        CBL_BRANCH_TRANSFER_BIT_SET,
        CBL_BRANCH_IRQ_ENABLED,
        CBL_BRANCH_IRQ_DISABLED,
        CBL_COPY_REGISTER,
        CBL_COPY_REGISTER_PAIR,
        CBL_LOAD_CONSTANT,
        CBL_LOAD_POINTER_INDIRECT,
        CBL_LOAD_POST_INC,
        CBL_LOAD_PRE_DEC,
        CBL_LOAD_WITH_OFFSET,
        CBL_LOAD_ABSOLUTE_ADDRESS
    } cbl_op_e;

    typedef enum logic [1:0] {
        CBL_PTR_X,
        CBL_PTR_Y,
        CBL_PTR_Z
    } cbl_ptr_e;

    typedef struct packed {
        cbl_op_e op;
        logic [REG_IDX_W-1:0] rd;
        logic [REG_IDX_W-1:0] rr;
        cbl_ptr_e ptr;
        logic [OFF_W-1:0] offset;
        logic [DISP_W-1:0] disp;
        logic [7:0] imm;
        logic [ADDR_W-1:0] abs_addr;
    } cbl_instr_s;

endpackage
